/* bench/spi_host_model.sv */
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// serial host model: mode 0, msb first, 16-bit frames, all moves just after clk
module spi_host_model (
    input  wire logic clk_i,
    output logic      cs_n_o,
    output logic      sclk_o,
    output logic      mosi_o,
    input  wire logic miso_i
);
    // clk cycles per sclk phase; raise it to act as a slow host
    int half_cyc = 2;

    // idle: deselected, sclk parked low
    initial
    begin
        cs_n_o = 1'b1;
        sclk_o = 1'b0;
        mosi_o = 1'b0;
    end

    task automatic step(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask

    // one frame: write flag, index, data; read byte sampled before each rise
    task automatic xfer(input logic wr, input logic [6:0] idx, input logic [7:0] wd,
                        output logic [7:0] rd);
        logic [15:0] frame;
        frame = {wr, idx, wd};
        rd = 8'h00;
        step(1);
        cs_n_o = 1'b0;
        for (int i = 15; i >= 0; i--)
        begin
            mosi_o = frame[i];
            step(half_cyc);
            if (i < 8)
                rd[i] = miso_i;
            sclk_o = 1'b1;
            step(half_cyc);
            sclk_o = 1'b0;
        end
        step(half_cyc);
        cs_n_o = 1'b1;
        mosi_o = ~mosi_o; // released line must not keep looking valid
        step(2);
    endtask
endmodule // spi_host_model

/* bench/wake_bus_timer_ctrl_regs_tb_top.sv */
`timescale 1ns/1ps
module wake_bus_timer_ctrl_regs_tb_top;
    import wake_bus_timer_pkg::*;

    localparam int T     = 4;     // short tick keeps periods in reach
    localparam int LIMIT = 90000; // well above the longest expected run

    logic       clk_i, rst_n_i, soft_reset_i, restart_i, restart_mode_i;
    logic       cyc_sense_sel_i, gp_hs_cleared_i, gp_is_wake_i, cyc_wake_source_en;
    logic       cs_n, sclk, mosi, miso, flash_mode_o, high_side_out, cyc_wake_evt_o;
    logic [1:0] wake_pin_pull_sel, gp_pin_wake_pull_sel;
    int         error_cnt = 0, samples_checked = 0, cyc_cnt = 0, w, p, n;
    int         on_tk[1:5]  = '{1, 3, 10, 100, 200};  // on-time in 0.1 ms ticks
    int         per_tk[0:3] = '{100, 200, 500, 1000}; // period in 0.1 ms ticks

    wake_bus_timer_ctrl_regs #(.TICK_CYCLES(T)) i_wake_bus_timer_ctrl_regs (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .soft_reset_i(soft_reset_i),
        .restart_i(restart_i), .restart_mode_i(restart_mode_i),
        .cyc_sense_sel_i(cyc_sense_sel_i), .gp_hs_cleared_i(gp_hs_cleared_i),
        .gp_is_wake_i(gp_is_wake_i), .cyc_wake_source_en(cyc_wake_source_en),
        .serial_chip_select_n(cs_n), .sclk_i(sclk), .mosi_i(mosi), .miso_o(miso),
        .wake_pin_pull_sel(wake_pin_pull_sel), .gp_pin_wake_pull_sel(gp_pin_wake_pull_sel),
        .flash_mode_o(flash_mode_o), .high_side_out(high_side_out),
        .cyc_wake_evt_o(cyc_wake_evt_o));

    spi_host_model i_spi_host_model (
        .clk_i(clk_i), .cs_n_o(cs_n), .sclk_o(sclk), .mosi_o(mosi), .miso_i(miso));

    ////////////////////////////////////////////////////////////////////////////
    // 10 MHz clock
    initial
    begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end

    // hang guard
    always @(posedge clk_i)
    begin
        cyc_cnt++;
        if (cyc_cnt == LIMIT)
        begin
            error_cnt++;
            $display("MISMATCH t=%0t run did not finish", $time);
            report_and_stop();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic step(input int k);
        repeat (k) @(posedge clk_i);
        #1;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("MISMATCH t=%0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        logic [7:0] x;
        i_spi_host_model.xfer(1'b1, a, d, x);
    endtask

    task automatic rd_chk(input logic [6:0] a, input logic [7:0] e);
        logic [7:0] x;
        i_spi_host_model.xfer(1'b0, a, 8'h00, x);
        check(x, e);
    endtask

    // high time and rise-to-rise time of the switch output, bounded wait
    task automatic meas(output int wd, output int pd);
        int k;
        k = 0;
        wd = 0;
        // sample just after each edge so the launching edge has settled
        while (high_side_out !== 1'b0 && k < 10000)
        begin
            step(1);
            k++;
        end
        while (high_side_out !== 1'b1 && k < 10000)
        begin
            step(1);
            k++;
        end
        while (high_side_out === 1'b1 && k < 10000)
        begin
            step(1);
            k++;
            wd++;
        end
        pd = wd;
        while (high_side_out === 1'b0 && k < 10000)
        begin
            step(1);
            k++;
            pd++;
        end
    endtask

    // wake pulses seen over two shortest periods
    task automatic count_evt(output int cnt);
        cnt = 0;
        repeat (2 * per_tk[0] * T)
        begin
            step(1);
            if (cyc_wake_evt_o === 1'b1)
                cnt++;
        end
    endtask

    task automatic report_and_stop();
        if (error_cnt == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        {soft_reset_i, restart_i, restart_mode_i, cyc_sense_sel_i} = 4'h0;
        {gp_hs_cleared_i, gp_is_wake_i, cyc_wake_source_en} = 3'h0;
        rst_n_i = 1'b0;
        step(12);
        rst_n_i = 1'b1;
        // power-on values, unmapped index ignored and reads zero
        rd_chk(ADDR_WAKE_PULL, 8'h00);
        rd_chk(ADDR_BUS_FLASH, 8'h00);
        rd_chk(ADDR_CYC_TIMER, 8'h00);
        check(high_side_out, 1'b0);
        wr(7'h05, 8'hff);
        rd_chk(7'h05, 8'h00);
        // every pull code on both fields, reserved bits written as ones
        for (int c = 0; c < 4; c++)
        begin
            wr(ADDR_WAKE_PULL, {c[1:0], 4'hf, c[1:0]});
            rd_chk(ADDR_WAKE_PULL, {c[1:0], 4'h0, c[1:0]});
            check(wake_pin_pull_sel, c);
            gp_is_wake_i = 1'b0;
            step(3);
            check(gp_pin_wake_pull_sel, 2'h0);
            gp_is_wake_i = 1'b1;
            step(3);
            check(gp_pin_wake_pull_sel, c);
        end
        // flash bit, once through a slow host
        i_spi_host_model.half_cyc = 3;
        wr(ADDR_BUS_FLASH, 8'hff);
        rd_chk(ADDR_BUS_FLASH, 8'h10);
        i_spi_host_model.half_cyc = 2;
        check(flash_mode_o, 1'b1);
        wr(ADDR_BUS_FLASH, 8'h00);
        check(flash_mode_o, 1'b0);
        wr(ADDR_BUS_FLASH, 8'h10);
        // reserved on-time code and the two stop codes
        wr(ADDR_CYC_TIMER, 8'hff);
        rd_chk(ADDR_CYC_TIMER, 8'h7f);
        step(6);
        check(high_side_out, 1'b0);
        wr(ADDR_CYC_TIMER, 8'h60);
        step(6);
        check(high_side_out, 1'b1);
        wr(ADDR_CYC_TIMER, 8'h00);
        step(6);
        check(high_side_out, 1'b0);
        // restart clears the timer only
        wr(ADDR_CYC_TIMER, 8'h60);
        restart_i = 1'b1;
        step(1);
        restart_i = 1'b0;
        rd_chk(ADDR_CYC_TIMER, 8'h00);
        rd_chk(ADDR_WAKE_PULL, 8'hc3);
        rd_chk(ADDR_BUS_FLASH, 8'h10);
        check(high_side_out, 1'b0);
        // every running on-time against a 50 ms period
        for (int c = 1; c < 6; c++)
        begin
            wr(ADDR_CYC_TIMER, {1'b0, c[2:0], 4'h2});
            meas(w, p);
            check(w, on_tk[c] * T);
            check(p, per_tk[2] * T);
        end
        // first period codes with the shortest on-time
        for (int c = 0; c < 4; c++)
        begin
            wr(ADDR_CYC_TIMER, {4'h1, c[3:0]});
            meas(w, p);
            check(p, per_tk[c] * T);
        end
        // wake source assigned before the on-time is set
        cyc_sense_sel_i = 1'b1;
        cyc_wake_source_en = 1'b1;
        wr(ADDR_CYC_TIMER, 8'h10);
        step(20);
        count_evt(n);
        check(n, 2);
        cyc_wake_source_en = 1'b0;
        step(2);
        count_evt(n);
        check(n, 0);
        // switch cleared outside and inside restart mode
        gp_hs_cleared_i = 1'b1;
        step(1);
        gp_hs_cleared_i = 1'b0;
        rd_chk(ADDR_CYC_TIMER, 8'h10);
        restart_mode_i = 1'b1;
        gp_hs_cleared_i = 1'b1;
        step(1);
        gp_hs_cleared_i = 1'b0;
        restart_mode_i = 1'b0;
        rd_chk(ADDR_CYC_TIMER, 8'h00);
        // soft reset clears all three
        wr(ADDR_CYC_TIMER, 8'h60);
        soft_reset_i = 1'b1;
        step(1);
        soft_reset_i = 1'b0;
        rd_chk(ADDR_WAKE_PULL, 8'h00);
        rd_chk(ADDR_BUS_FLASH, 8'h00);
        rd_chk(ADDR_CYC_TIMER, 8'h00);
        check(high_side_out, 1'b0);
        report_and_stop();
    end
endmodule // wake_bus_timer_ctrl_regs_tb_top

/* src/cyclic_timer.sv */
`timescale 1ns/1ps
module cyclic_timer
    import wake_bus_timer_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYC_DEF
) (
    input  wire logic     clk_i,
    input  wire logic     rst_n_i,
    input  wire tmr_cfg_t cfg_i,
    input  wire logic     load_i,
    input  wire logic     wake_en_i,
    output logic          high_side_out_o,
    output logic          wake_evt_o
);

    logic [31:0]   presc_r;
    logic [TW-1:0] per_cnt_r;
    logic          running;
    logic          tick;
    logic          per_end;

    // only codes 1..5 run; stop codes and the reserved code hold still
    assign running = (cfg_i.on_code != ON_STOP_LOW) && (cfg_i.on_code != ON_STOP_HIGH)
                     && (cfg_i.on_code != ON_RSVD);
    assign tick    = running && (presc_r == 32'(TICK_CYCLES - 1));
    assign per_end = per_cnt_r == (per_ticks(cfg_i.per_code) - TW'(1));

    // tick prescaler; a new setting restarts the cycle from its start
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i || load_i || !running)
            presc_r <= '0;
        else if (tick)
            presc_r <= '0;
        else
            presc_r <= presc_r + 32'd1;
    end

    // position inside the period, in ticks
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i || load_i || !running)
            per_cnt_r <= '0;
        else if (tick)
            per_cnt_r <= per_end ? '0 : per_cnt_r + TW'(1);
    end

    // switch drive: on phase at the start of each period
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
            high_side_out_o <= 1'b0;
        else if (running)
            high_side_out_o <= per_cnt_r < on_ticks(cfg_i.on_code);
        else
            high_side_out_o <= cfg_i.on_code == ON_STOP_HIGH;
    end

    // wake runs beside sense, sharing the same period
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
            wake_evt_o <= 1'b0;
        else
            wake_evt_o <= wake_en_i && tick && per_end;
    end

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    stop_low_a: assert property ((cfg_i.on_code == ON_STOP_LOW || cfg_i.on_code == ON_RSVD)
        [*2] |=> !high_side_out_o && !wake_evt_o)
        else $error("timer output not low while stopped");
    stop_high_a: assert property ((cfg_i.on_code == ON_STOP_HIGH) [*2] |=> high_side_out_o)
        else $error("timer output not high in stop-high");
    wake_gate_a: assert property (wake_evt_o |-> $past(wake_en_i) && $past(running))
        else $error("wake event without enable");
    start_on_a: assert property ($rose(running) |=> high_side_out_o)
        else $error("output not on at period start");

endmodule // cyclic_timer

/* src/wake_bus_timer_ctrl_regs.sv */
`timescale 1ns/1ps
// Notes on behaviour
// - wake pin pull field bits 1:0: none, down, up, automatic.
// - general pin pull field bits 7:6, same codes, only when pin is wake input.
// - reserved bits ignore writes and read as zero.
// - pull register clears on power-on and soft reset; restart keeps both fields.
// - bus register bit 4 selects flash mode, removing slew control above 5 MBaud.
// - flash bit clears on power-on and soft reset, survives restart.
// - on-time bits 6:4 decode to 0.1, 0.3, 1, 10, 20 ms; 111 reserved.
// - on-time 000 stops timer output low; 110 stops it output high.
// - period bits 3:0 decode 10 ms up to 100 s in increasing steps.
// - software assigns timer first; timer starts once a running on-time is set.
// - sense selected and switch cleared in restart mode clears timer fields.
// - timer wake while sense runs gives both sense and wake together.
// - new timer setting takes effect at chip-select rise ending the write.
// - timer register clears on power-on, soft reset and restart.
// - a separate wake control enable decides if the timer is a wake source.
module wake_bus_timer_ctrl_regs
    import wake_bus_timer_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYC_DEF
) (
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    input  wire logic soft_reset_i,
    input  wire logic restart_i,
    input  wire logic restart_mode_i,
    input  wire logic cyc_sense_sel_i,
    input  wire logic gp_hs_cleared_i,
    input  wire logic gp_is_wake_i,
    input  wire logic cyc_wake_source_en,
    input  wire logic serial_chip_select_n,
    input  wire logic sclk_i,
    input  wire logic mosi_i,
    output logic      miso_o,
    output logic [1:0] wake_pin_pull_sel,
    output logic [1:0] gp_pin_wake_pull_sel,
    output logic      flash_mode_o,
    output logic      high_side_out,
    output logic      cyc_wake_evt_o
);

    logic [7:0]  wake_pull_r;
    logic [7:0]  bus_flash_r;
    tmr_cfg_t    cyc_cfg_r;
    logic        cfg_load_r;
    spi_st_t     spi_st_r;
    logic        cs_n_prev_r;
    logic        sclk_prev_r;
    logic [4:0]  bit_cnt_r;
    logic [15:0] shift_in_r;
    logic [7:0]  miso_sh_r;
    logic        cs_fall;
    logic        cs_rise;
    logic        sclk_rise;
    logic        sclk_fall;
    logic        commit;
    logic [6:0]  wr_addr;
    logic [7:0]  wr_data;
    logic        tmr_clear;
    logic        tmr_write;

    ////////////////////////////////////////////////////////////////////////////
    // serial frame: command byte (bit 7 write, 6:0 index), then data byte, msb first

    assign cs_fall   = cs_n_prev_r && !serial_chip_select_n;
    assign cs_rise   = !cs_n_prev_r && serial_chip_select_n;
    assign sclk_rise = !serial_chip_select_n && !sclk_prev_r && sclk_i;
    assign sclk_fall = !serial_chip_select_n && sclk_prev_r && !sclk_i;
    assign wr_addr   = shift_in_r[14:8];
    assign wr_data   = shift_in_r[7:0];
    // frames of any other length are dropped whole
    assign commit    = cs_rise && (bit_cnt_r == FRAME_BITS) && shift_in_r[15];

    // read mux; unmapped indices answer zero
    function automatic logic [7:0] rd_mux(input logic [6:0] a);
        if (a == ADDR_WAKE_PULL)
            return wake_pull_r & MASK_WAKE_PULL;
        else if (a == ADDR_BUS_FLASH)
            return bus_flash_r & MASK_BUS_FLASH;
        else if (a == ADDR_CYC_TIMER)
            return {1'b0, cyc_cfg_r};
        else
            return 8'h00;
    endfunction

    // edge history of the serial pins
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            cs_n_prev_r <= 1'b1;
            sclk_prev_r <= 1'b0;
        end
        else
        begin
            cs_n_prev_r <= serial_chip_select_n;
            sclk_prev_r <= sclk_i;
        end
    end

    // bit capture and phase tracking
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            spi_st_r   <= SPI_IDLE;
            bit_cnt_r  <= '0;
            shift_in_r <= '0;
        end
        else
        begin
            case (spi_st_r)
                SPI_IDLE:
                    if (cs_fall)
                    begin
                        spi_st_r  <= SPI_CMD;
                        bit_cnt_r <= '0;
                    end
                SPI_CMD, SPI_DAT:
                    if (serial_chip_select_n)
                        spi_st_r <= SPI_IDLE;
                    else if (sclk_rise)
                    begin
                        shift_in_r <= {shift_in_r[14:0], mosi_i};
                        // saturate so long frames never alias to a valid length
                        if (bit_cnt_r != OVER_BITS)
                            bit_cnt_r <= bit_cnt_r + 5'd1;
                        if (bit_cnt_r == CMD_BITS - 5'd1)
                            spi_st_r <= SPI_DAT;
                    end
                default:
                    spi_st_r <= SPI_IDLE;
            endcase
        end
    end

    // read data loads after the command byte and shifts on falling clock
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i || serial_chip_select_n)
        begin
            miso_sh_r <= '0;
            miso_o    <= 1'b0;
        end
        else if (spi_st_r == SPI_CMD && sclk_rise && bit_cnt_r == CMD_BITS - 5'd1)
            miso_sh_r <= rd_mux({shift_in_r[5:0], mosi_i});
        else if (spi_st_r == SPI_DAT && sclk_fall)
        begin
            miso_o    <= miso_sh_r[7];
            miso_sh_r <= {miso_sh_r[6:0], 1'b0};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // register storage; resets win over a write in the same cycle

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i || soft_reset_i)
            wake_pull_r <= RST_WAKE_PULL;
        else if (commit && wr_addr == ADDR_WAKE_PULL)
            wake_pull_r <= wr_data & MASK_WAKE_PULL;
    end

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i || soft_reset_i)
            bus_flash_r <= RST_BUS_FLASH;
        else if (commit && wr_addr == ADDR_BUS_FLASH)
            bus_flash_r <= wr_data & MASK_BUS_FLASH;
    end

    // switch clear in restart would otherwise leave sense misreading the pin
    assign tmr_clear = soft_reset_i || restart_i
                       || (restart_mode_i && cyc_sense_sel_i && gp_hs_cleared_i);
    assign tmr_write = commit && wr_addr == ADDR_CYC_TIMER;

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i || tmr_clear)
            cyc_cfg_r <= tmr_cfg_t'(RST_CYC_TIMER[6:0]);
        else if (tmr_write)
            cyc_cfg_r <= tmr_cfg_t'(wr_data[6:0]);
    end

    // restart the cycle whenever the setting changes
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
            cfg_load_r <= 1'b0;
        else
            cfg_load_r <= tmr_clear || tmr_write;
    end

    ////////////////////////////////////////////////////////////////////////////
    // pin controls

    assign wake_pin_pull_sel = wake_pull_r[WPULL_LSB +: 2];
    assign flash_mode_o      = bus_flash_r[FLASH_BIT];

    // general pin pull only applies while that pin serves as wake input
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
            gp_pin_wake_pull_sel <= PULL_NONE;
        else
            gp_pin_wake_pull_sel <= gp_is_wake_i ? wake_pull_r[GPULL_LSB +: 2] : PULL_NONE;
    end

    cyclic_timer #(
        .TICK_CYCLES (TICK_CYCLES)
    ) u_timer (
        .clk_i           (clk_i),
        .rst_n_i         (rst_n_i),
        .cfg_i           (cyc_cfg_r),
        .load_i          (cfg_load_r),
        .wake_en_i       (cyc_wake_source_en),
        .high_side_out_o (high_side_out),
        .wake_evt_o      (cyc_wake_evt_o)
    );

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    sequence tmr_wr_s;
        tmr_write && !tmr_clear;
    endsequence

    pull_rsvd_a: assert property ((wake_pull_r & ~MASK_WAKE_PULL) == 8'h00
        && (bus_flash_r & ~MASK_BUS_FLASH) == 8'h00)
        else $error("reserved bit stored");
    soft_clear_a: assert property (soft_reset_i |=> wake_pull_r == 8'h00
        && bus_flash_r == 8'h00 && cyc_cfg_r == '0)
        else $error("soft reset did not clear");
    restart_keep_a: assert property (restart_i && !soft_reset_i && !commit
        |=> $stable(wake_pull_r) && $stable(bus_flash_r))
        else $error("restart changed kept fields");
    restart_tmr_a: assert property (tmr_clear |=> cyc_cfg_r == '0 && cfg_load_r)
        else $error("timer not cleared");
    tmr_commit_a: assert property (tmr_wr_s |=> cyc_cfg_r == $past(wr_data[6:0])
        ##0 cfg_load_r)
        else $error("timer write not applied at frame end");
    gp_gate_a: assert property (!gp_is_wake_i |=> gp_pin_wake_pull_sel == PULL_NONE)
        else $error("gp pull active without wake use");
    no_commit_a: assert property (!commit && !soft_reset_i |=> $stable(bus_flash_r))
        else $error("flash bit changed without write");

endmodule // wake_bus_timer_ctrl_regs

/* src/wake_bus_timer_pkg.sv */
package wake_bus_timer_pkg;

    // register indices as seen in the serial command byte
    localparam logic [6:0] ADDR_WAKE_PULL = 7'h08;
    localparam logic [6:0] ADDR_BUS_FLASH = 7'h0b;
    localparam logic [6:0] ADDR_CYC_TIMER = 7'h0c;

    // values after power-on and soft reset
    localparam logic [7:0] RST_WAKE_PULL  = 8'h00;
    localparam logic [7:0] RST_BUS_FLASH  = 8'h00;
    localparam logic [7:0] RST_CYC_TIMER  = 8'h00;

    // implemented bits; everything else is reserved and reads zero
    localparam logic [7:0] MASK_WAKE_PULL = 8'hc3;
    localparam logic [7:0] MASK_BUS_FLASH = 8'h10;
    localparam logic [7:0] MASK_CYC_TIMER = 8'h7f;

    // field positions
    localparam int WPULL_LSB = 0;
    localparam int GPULL_LSB = 6;
    localparam int FLASH_BIT = 4;
    localparam int ON_LSB    = 4;
    localparam int PER_LSB   = 0;

    // pull selection codes
    localparam logic [1:0] PULL_NONE = 2'h0;
    localparam logic [1:0] PULL_DOWN = 2'h1;
    localparam logic [1:0] PULL_UP   = 2'h2;
    localparam logic [1:0] PULL_AUTO = 2'h3;

    // on-time codes that do not run the timer
    localparam logic [2:0] ON_STOP_LOW  = 3'h0;
    localparam logic [2:0] ON_STOP_HIGH = 3'h6;
    localparam logic [2:0] ON_RSVD      = 3'h7;

    // serial frame layout
    localparam logic [4:0] CMD_BITS   = 5'd8;
    localparam logic [4:0] FRAME_BITS = 5'd16;
    localparam logic [4:0] OVER_BITS  = 5'd17;

    // timing: the timer counts in ticks of 0.1 ms
    localparam int CLK_HZ       = 10_000_000;
    localparam int TICK_US      = 100;
    localparam int TICK_CYC_DEF = TICK_US * (CLK_HZ / 1_000_000);
    localparam int TW           = 20;

    typedef enum logic [2:0] {
        SPI_IDLE = 3'b001,
        SPI_CMD  = 3'b010,
        SPI_DAT  = 3'b100
    } spi_st_t;

    typedef struct packed {
        logic [2:0] on_code;
        logic [3:0] per_code;
    } tmr_cfg_t;

    function automatic logic [TW-1:0] us_ticks(input int us);
        return TW'(us / TICK_US);
    endfunction

    // on-time table; stop codes give zero
    function automatic logic [TW-1:0] on_ticks(input logic [2:0] c);
        case (c)
            3'h1:    return us_ticks(100);
            3'h2:    return us_ticks(300);
            3'h3:    return us_ticks(1_000);
            3'h4:    return us_ticks(10_000);
            3'h5:    return us_ticks(20_000);
            default: return '0;
        endcase
    endfunction

    // period table; codes above the last printed one hold 100 s
    function automatic logic [TW-1:0] per_ticks(input logic [3:0] c);
        case (c)
            4'h0:    return us_ticks(10_000);
            4'h1:    return us_ticks(20_000);
            4'h2:    return us_ticks(50_000);
            4'h3:    return us_ticks(100_000);
            4'h4:    return us_ticks(200_000);
            4'h5:    return us_ticks(500_000);
            4'h6:    return us_ticks(1_000_000);
            4'h7:    return us_ticks(2_000_000);
            4'h8:    return us_ticks(5_000_000);
            4'h9:    return us_ticks(10_000_000);
            4'ha:    return us_ticks(20_000_000);
            4'hb:    return us_ticks(50_000_000);
            default: return us_ticks(100_000_000);
        endcase
    endfunction

endpackage
